/* File: address_latch_strobe_gen.v */
`timescale 1ns/10ps
`default_nettype none
`include "ale_gen_defines.vh"

// Function
// - Strobe external memory accesses only at the pulse phase
// - 12-clock mode pulses at one sixth
// - Skip the next pulse after one or more data accesses
// - 6-clock mode pulses at one third
// - Pin becomes programming pulse input
// - Oscillator output toggles every system clock
// - Reserved bits written zero, read any
// - Fixed-zero bits always read zero
module address_latch_strobe_gen #(
    parameter PERIOD_12 = `PERIOD_12CLK,
    parameter PERIOD_6 = `PERIOD_6CLK
) (
    input wire sys_clk_i,
    input wire rst_i,
    input wire six_clock_mode_i,
    input wire ext_access_i,
    input wire ext_data_access_i,
    input wire program_mode_i,
    input wire aux_write_i,
    input wire [7:0] aux_wdata_i,
    input wire program_pulse_input,
    output reg [7:0] aux_rdata_o,
    output reg strobe_o,
    output reg strobe_oe_n_o,
    output reg program_pulse_o,
    output reg oscillator_output
);

    // ==========================================
    // Mode constants
    // Periods must fit the four-bit phase counter
    localparam [3:0] SLOW_PERIOD = PERIOD_12;
    localparam [3:0] FAST_PERIOD = PERIOD_6;

    // ==========================================
    // Declarations
    reg [7:0] aux;
    reg [7:0] next_aux;
    reg [3:0] phase;
    reg [3:0] next_phase;
    reg skip_pending;
    reg next_skip_pending;
    reg [2:0] program_pulse_input_sync;
    reg next_strobe;
    reg next_program_pulse_input_pulse;
    wire strobe_disable_bit;
    wire [3:0] period;
    wire [3:0] phase_inc;
    wire wrap;
    wire slot;
    wire program_pulse_input_stable;

    // ==========================================
    // Derived control
    assign strobe_disable_bit = aux[`AUX_DISABLE_BIT];
    assign period = six_clock_mode_i ? FAST_PERIOD : SLOW_PERIOD;
    assign phase_inc = phase + `PHASE_STEP;
    assign wrap = (phase_inc >= period);
    assign slot = (phase == `PULSE_PHASE);
    // Only trust the pin once two stages agree
    assign program_pulse_input_stable = (program_pulse_input_sync[2] == program_pulse_input_sync[1]);

    // ==========================================
    // Next auxiliary value
    always @* begin
        next_aux = aux;
        if (aux_write_i) begin
            next_aux = aux_wdata_i & `AUX_WRITE_MASK;
        end
    end

    // ==========================================
    // Next phase
    always @* begin
        next_phase = phase_inc;
        if (wrap) begin
            next_phase = `PHASE_RESET;
        end
    end

    // ==========================================
    // Next skip state
    always @* begin
        next_skip_pending = skip_pending;
        if (ext_data_access_i) begin
            next_skip_pending = 1'b1;
        end else if (slot) begin
            next_skip_pending = 1'b0;
        end
    end

    // ==========================================
    // Next strobe
    // Disable stops free running, access still strobes
    always @* begin
        next_strobe = 1'b0;
        if (slot && !skip_pending) begin
            if (!strobe_disable_bit || ext_access_i) begin
                next_strobe = 1'b1;
            end
        end
        if (program_mode_i) begin
            next_strobe = 1'b0;
        end
    end

    // ==========================================
    // Next programming pulse
    always @* begin
        next_program_pulse_input_pulse = program_pulse_o;
        if (program_pulse_input_stable) begin
            next_program_pulse_input_pulse = program_pulse_input_sync[2] & program_mode_i;
        end
    end

    // ==========================================
    // Auxiliary register
    always @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            aux <= `AUX_RESET;
        end else begin
            aux <= next_aux;
        end
    end

    // ==========================================
    // Auxiliary readback
    always @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            aux_rdata_o <= `AUX_RESET;
        end else begin
            aux_rdata_o <= aux & `AUX_WRITE_MASK;
        end
    end

    // ==========================================
    // Phase counter
    always @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            phase <= `PHASE_RESET;
        end else begin
            phase <= next_phase;
        end
    end

    // ==========================================
    // Skip flag
    // Several data accesses before one slot drop one pulse
    always @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            skip_pending <= 1'b0;
        end else begin
            skip_pending <= next_skip_pending;
        end
    end

    // ==========================================
    // Strobe output
    always @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            strobe_o <= 1'b0;
        end else begin
            strobe_o <= next_strobe;
        end
    end

    // ==========================================
    // Pin direction
    always @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            strobe_oe_n_o <= 1'b0;
        end else begin
            strobe_oe_n_o <= program_mode_i;
        end
    end

    // ==========================================
    // Pin synchroniser
    always @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            program_pulse_input_sync <= `SYNC_RESET;
        end else begin
            program_pulse_input_sync <= {program_pulse_input_sync[1:0], program_pulse_input};
        end
    end

    // ==========================================
    // Programming pulse output
    always @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            program_pulse_o <= 1'b0;
        end else begin
            program_pulse_o <= next_program_pulse_input_pulse;
        end
    end

    // ==========================================
    // Oscillator image
    // Toggle model only; no analogue amplifier here
    always @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            oscillator_output <= 1'b0;
        end else begin
            oscillator_output <= ~oscillator_output;
        end
    end

    // ==========================================
    // Fixed bits
    // no fixed-one bits exist here

endmodule // address_latch_strobe_gen
`default_nettype wire

/* File: ale_gen_defines.vh */
`ifndef ALE_GEN_DEFINES_VH
`define ALE_GEN_DEFINES_VH
// Clocks per strobe period in each mode
`define PERIOD_12CLK 4'h6
`define PERIOD_6CLK 4'h3
// Phase inside the period that raises the strobe on the next clock
`define PULSE_PHASE 4'h0
`define PHASE_RESET 4'h0
`define PHASE_STEP 4'h1
// Auxiliary register layout: bit0 strobe disable, bit1 extram, rest reserved
`define AUX_DISABLE_BIT 0
`define AUX_EXTRAM_BIT 1
`define AUX_RESET 8'h00
`define AUX_WRITE_MASK 8'h03
`define SYNC_RESET 3'h0
`endif

/* File: ext_program_pulse_input.sv */
`timescale 1ns/10ps
`default_nettype none
module ext_program_pulse_input(input wire logic on_i, input wire logic l_i, output wire logic p_o);
assign p_o = on_i ? l_i : 1'b1;
endmodule // ext_program_pulse_input
`default_nettype wire

/* File: ale_strobe_asserts.sv */
`timescale 1ns/10ps
`default_nettype none
module ale_chk(input wire logic sys_clk_i, input wire logic rst_i, input wire logic program_mode_i,
 input wire logic ext_access_i, input wire logic strobe_o, input wire logic strobe_oe_n_o,
 input wire logic [7:0] aux_rdata_o, input wire logic oscillator_output);
default clocking @(posedge sys_clk_i); endclocking
default disable iff (rst_i);
property p_w; strobe_o |=> !strobe_o; endproperty
a_w: assert property (p_w) else $error("wide strobe");
property p_p; program_mode_i |=> !strobe_o; endproperty
a_p: assert property (p_p) else $error("strobe in pm");
property p_gap; strobe_o |=> !strobe_o ##1 !strobe_o; endproperty
a_gap: assert property (p_gap) else $error("strobe period short");
property p_oe; program_mode_i |=> strobe_oe_n_o; endproperty
a_oe: assert property (p_oe) else $error("pin not released");
property p_rsv; aux_rdata_o[7:2] == 6'h00; endproperty
a_rsv: assert property (p_rsv) else $error("reserved bit set");
property p_dis; aux_rdata_o[0] && !ext_access_i |=> !strobe_o; endproperty
a_dis: assert property (p_dis) else $error("strobe while disabled");
property p_osc; !rst_i |=> oscillator_output != $past(oscillator_output); endproperty
a_osc: assert property (p_osc) else $error("oscillator stuck");
c_a: cover property (strobe_o); c_b: cover property (program_mode_i); c_c: cover property (strobe_o ##3 strobe_o);
endmodule // ale_chk
bind address_latch_strobe_gen ale_chk i_c(.sys_clk_i(sys_clk_i), .rst_i(rst_i), .program_mode_i(program_mode_i),
 .ext_access_i(ext_access_i), .strobe_o(strobe_o), .strobe_oe_n_o(strobe_oe_n_o), .aux_rdata_o(aux_rdata_o),
 .oscillator_output(oscillator_output));
`default_nettype wire

/* File: testbench.sv */
`timescale 1ns/10ps
`default_nettype none
module testbench;
logic sys_clk_i=0, rst_i=1, sm=0, xa=0, xd=0, pm=0, aw=0, pl=0, ex, dis, rn=0, pp, so, po, oe, os, eo, ov;
logic [7:0] ar, er, da;
int r=32'hfa29bd1a, miscompares=0, checked=0, ph, pend, cyc;
always #20 sys_clk_i = ~sys_clk_i;
address_latch_strobe_gen i_address_latch_strobe_gen(.sys_clk_i, .rst_i, .six_clock_mode_i(sm), .ext_access_i(xa),
 .ext_data_access_i(xd), .program_mode_i(pm), .aux_write_i(aw), .aux_wdata_i({6'h00, {2{aw}}}),
 .program_pulse_input(pp),
 .aux_rdata_o(ar), .strobe_o(so), .strobe_oe_n_o(oe), .program_pulse_o(po), .oscillator_output(os));
ext_program_pulse_input i_ext_program_pulse_input(.on_i(pm), .l_i(pl), .p_o(pp));
function int lfsr(int v); return {v[30:0], ^(v & 32'h80200003)}; endfunction
task chk(logic [7:0] s, logic [7:0] e); checked++; if (s !== e) begin miscompares++; $display("BAD %0t mismatch", $time); end endtask
task w(int n); repeat (n) @(negedge sys_clk_i); endtask
task conclude; if (miscompares == 0 && checked > 0) $display("SIMULATION PASSED");
else $display("SIMULATION FAILED"); $finish; endtask
always @(posedge sys_clk_i) begin
    ex = !rst_i && ph == 0 && !pm && !pend && (!dis || xa);
    pend = !rst_i && (ph != 0 && pend || xd);
    dis = !rst_i && (aw || dis);
    ph = rst_i ? 0 : (ph + 1) % (sm ? 3 : 6);
    er = rst_i ? 8'h00 : da;
    da = rst_i ? 8'h00 : (aw ? 8'h03 : da);
    eo = !rst_i && pm;
    ov = !rst_i && !ov;
    if (++cyc > 900) begin miscompares++; conclude; end
end
always @(negedge sys_clk_i) begin
    r = lfsr(r);
    xd <= rn && ph != 0 && r[0];
    if (!rst_i) chk(so, ex);
    if (!rst_i) chk(ar, er);
    if (!rst_i) chk(oe, eo);
    if (!rst_i) chk(os, ov);
end
initial begin
    for (int m = 0; m < 2; m++) begin
        rst_i = 1; sm = m[0]; w(6); rst_i = 0; rn = 1; w(60); rn = 0; w(8);
        // aux write only sets disable and extram
        aw = 1; w(1); aw = 0; w(20); xa = 1; w(20); xa = 0;
    end
    pm = 1; pl = 1; w(8); chk(po, 1'b1); pl = 0; w(8); chk(po, 1'b0);
    conclude;
end
endmodule // testbench
`default_nettype wire
